// [core/tws_pkg.sv]
// constants, register map and state codes of the two-wire slave engine
package tws_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD  = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0c;
    localparam logic [7:0] OFF_DATA = 8'h10;

    // control register fields
    localparam int unsigned CTRL_EN     = 3;
    localparam int unsigned CTRL_STOPEN = 2;
    localparam int unsigned CTRL_ALL    = 1;

    // command register fields
    localparam int unsigned CMD_ACK = 2;
    localparam int unsigned CMD_HI  = 1;
    localparam int unsigned CMD_LO  = 0;

    // status register fields
    localparam int unsigned STAT_DF  = 7;
    localparam int unsigned STAT_AF  = 6;
    localparam int unsigned STAT_CH  = 5;
    localparam int unsigned STAT_RA  = 4;
    localparam int unsigned STAT_COL = 3;
    localparam int unsigned STAT_BE  = 2;
    localparam int unsigned STAT_DIR = 1;
    localparam int unsigned STAT_AS  = 0;

    // address register fields
    localparam int unsigned ADDR_GC = 0;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // command codes
    localparam logic [1:0] CMD_DONE = 2'h2;
    localparam logic [1:0] CMD_NEXT = 2'h3;

    // general call address
    localparam logic [6:0] GC_ADDR = 7'h00;

    // engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_HOLD = 3'b010,
        ST_ACK  = 3'b011,
        ST_RX   = 3'b100,
        ST_TXW  = 3'b101,
        ST_TX   = 3'b110,
        ST_TACK = 3'b111
    } tws_state_e;

endpackage

// [core/tws_linemon.sv]
// line synchronisers and bus condition detector
`timescale 1ns/1ps
`default_nettype none

module tws_linemon (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    output logic      scl_s,
    output logic      sda_s,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);

    logic scl_m;
    logic sda_m;
    logic scl_d;
    logic sda_d;

    ////////////////////////////////////////////////////////////////////////
    // two flops per line; bus idles high so reset to one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m <= 1'b1;
            sda_m <= 1'b1;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_pin;
            sda_m <= sda_pin;
            scl_s <= scl_m;
            sda_s <= sda_m;
        end
    end

    // third stage only for edge finding, never the metastable one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sda moving while scl stays high marks start or stop
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

endmodule // tws_linemon

`default_nettype wire

// [core/tws_slave.sv]
// two-wire slave engine with its register file on an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - start seen while asleep holds scl low until wake-up ends
// - scl is only pulled low after it has been seen low
// - clock stretched before the ack bit of a received byte, after it for a read address or sent byte
// - no bus timeout; a stalled bus waits for software
// - separate data and address/stop flags, polled by software
// - status shows received ack, clock hold, collision, bus error, direction
// - either event flag pending holds scl low until serviced
// - accept-all mode matches every address
// - address compared after start; match stretched for software, mismatch left released
// - address/stop flag set on own address match or general call
// - stop straight after start flags a bus error
// - direction flag keeps the read/write bit of the address
// - read address: stretch; ack sets data flag, refusal waits for start
// - write address: stretch; ack expects data, refusal waits for start
// - collision sets flag, drops data/ack drive, frees scl, awaits start
// - stop sets address/stop flag marked as stop, not address
// - each received byte sets data flag and is acked or refused
// - loading data register starts transmit; master refusal ends it
// - a command write frees scl and clears hold and event flags
// - stop sets address/stop flag only when stop events enabled
// - sda changes only while scl is low
module tws_slave (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    input  wire logic        sleeping
);

    tws_pkg::tws_state_e state_q;

    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       wsel_q;
    logic [7:0] wadr_q;
    logic [7:0] rd_q;
    logic [7:0] ctrl_q;
    logic [7:0] own_q;
    logic [7:0] txd_q;
    logic [7:0] rxd_q;
    logic       ack_act_q;
    logic       dflag_q;
    logic       aflag_q;
    logic       coll_q;
    logic       berr_q;
    logic       dir_q;
    logic       as_addr_q;
    logic       rnack_q;
    logic       wake_q;
    logic       drv_q;
    logic       sda_drv_q;
    logic [7:0] sh_q;
    logic [2:0] cnt_q;
    logic       is_addr_q;
    logic       pend_q;
    logic [1:0] cmd_q;
    logic       tx_pend_q;
    logic [7:0] in_byte;
    logic       en;
    logic       wr_ctrl;
    logic       wr_cmd;
    logic       wr_stat;
    logic       wr_addr;
    logic       wr_data;
    logic       cmd_go;
    logic       ev_start;
    logic       ev_stop;
    logic       ev_berr;
    logic       ev_addr;
    logic       ev_rx;
    logic       ev_tack;
    logic       ev_coll;
    logic       ev_ackend;
    logic       hold_req;
    logic       last_rise;

    // address compare, also used for the captured address byte
    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] own,
                                      input logic all);
        addr_hit = all | (b[7:1] == own[7:1]) |
                   (own[tws_pkg::ADDR_GC] & (b[7:1] == tws_pkg::GC_ADDR));
    endfunction

    // read mux, shared by every readable offset
    function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] ctrl,
                                          input logic [7:0] stat, input logic [7:0] own,
                                          input logic [7:0] rxd, input logic ack);
        case (a)
            tws_pkg::OFF_CTRL: rd_mux = ctrl;
            tws_pkg::OFF_CMD:  rd_mux = {5'h00, ack, 2'h0};
            tws_pkg::OFF_STAT: rd_mux = stat;
            tws_pkg::OFF_ADDR: rd_mux = own;
            tws_pkg::OFF_DATA: rd_mux = rxd;
            default:           rd_mux = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and start/stop detection
    tws_linemon u_linemon (
        .clk       (hclk),
        .rst_n     (hresetn),
        .scl_pin   (scl_i),
        .sda_pin   (sda_i),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = {24'h000000, rd_q};

    // latch the write address phase; reads are fetched in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wsel_q <= 1'b0;
            wadr_q <= 8'h00;
            rd_q   <= 8'h00;
        end else begin
            wsel_q <= hsel & hready & htrans[1] & hwrite;
            wadr_q <= haddr[7:0];
            if (hsel & hready & htrans[1] & ~hwrite) begin
                rd_q <= rd_mux(haddr[7:0], ctrl_q,
                               {dflag_q, aflag_q, drv_q, rnack_q,
                                coll_q, berr_q, dir_q, as_addr_q},
                               own_q, rxd_q, ack_act_q);
            end else begin
                rd_q <= 8'h00;
            end
        end
    end

    assign wr_ctrl = wsel_q & (wadr_q == tws_pkg::OFF_CTRL);
    assign wr_cmd  = wsel_q & (wadr_q == tws_pkg::OFF_CMD);
    assign wr_stat = wsel_q & (wadr_q == tws_pkg::OFF_STAT);
    assign wr_addr = wsel_q & (wadr_q == tws_pkg::OFF_ADDR);
    assign wr_data = wsel_q & (wadr_q == tws_pkg::OFF_DATA);
    assign cmd_go  = wr_cmd & hwdata[tws_pkg::CMD_HI];
    assign en      = ctrl_q[tws_pkg::CTRL_EN];

    // software-written settings steering the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q    <= tws_pkg::CTRL_RST;
            own_q     <= tws_pkg::ADDR_RST;
            txd_q     <= tws_pkg::DATA_RST;
            ack_act_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {4'h0, hwdata[3:1], 1'b0};
            end
            if (wr_addr) begin
                own_q <= hwdata[7:0];
            end
            if (wr_data) begin
                txd_q <= hwdata[7:0];
            end
            if (wr_cmd) begin
                ack_act_q <= hwdata[tws_pkg::CMD_ACK]; // ack action lands in the same cycle as the command
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus events seen by the engine
    assign in_byte   = {sh_q[6:0], sda_s};
    assign last_rise = scl_rise & (cnt_q == 3'h7);
    assign ev_start  = en & start_det;
    assign ev_stop   = en & stop_det;
    assign ev_berr   = ev_stop & (state_q == tws_pkg::ST_ADDR) & (cnt_q <= 3'h1);
    assign ev_addr   = (state_q == tws_pkg::ST_ADDR) & last_rise &
                       addr_hit(in_byte, own_q, ctrl_q[tws_pkg::CTRL_ALL]);
    assign ev_rx     = (state_q == tws_pkg::ST_RX) & last_rise;
    assign ev_tack   = (state_q == tws_pkg::ST_TACK) & scl_rise & ~sda_s;
    assign ev_ackend = (state_q == tws_pkg::ST_ACK) & scl_fall;
    // released sda found low while we meant high or a refusal
    assign ev_coll   = ((state_q == tws_pkg::ST_TX) | (state_q == tws_pkg::ST_ACK)) &
                       scl_rise & ~sda_drv_q & ~sda_s;

    ////////////////////////////////////////////////////////////////////////
    // data event flag: hardware set wins over any clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dflag_q <= 1'b0;
        end else if (ev_rx | ev_tack |
                     (ev_ackend & (cmd_q == tws_pkg::CMD_NEXT) & dir_q & is_addr_q &
                      ~ack_act_q)) begin
            dflag_q <= 1'b1;
        end else if (cmd_go | ev_coll | (wr_stat & hwdata[tws_pkg::STAT_DF]) |
                     (wr_data & (state_q == tws_pkg::ST_TXW))) begin
            dflag_q <= 1'b0;
        end
    end

    // address/stop flag with its address-or-stop marker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aflag_q   <= 1'b0;
            as_addr_q <= 1'b0;
        end else if (ev_addr) begin
            aflag_q   <= 1'b1;
            as_addr_q <= 1'b1;
        end else if (ev_stop & ~ev_berr & ctrl_q[tws_pkg::CTRL_STOPEN]) begin
            aflag_q   <= 1'b1;
            as_addr_q <= 1'b0;
        end else if (cmd_go | ev_coll | (wr_stat & hwdata[tws_pkg::STAT_AF])) begin
            aflag_q   <= 1'b0;
        end
    end

    // error and status indications for polling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coll_q  <= 1'b0;
            berr_q  <= 1'b0;
            dir_q   <= 1'b0;
            rnack_q <= 1'b0;
        end else begin
            if (ev_coll) begin
                coll_q <= 1'b1;
            end else if (wr_stat & hwdata[tws_pkg::STAT_COL]) begin
                coll_q <= 1'b0;
            end
            if (ev_berr) begin
                berr_q <= 1'b1;
            end else if (wr_stat & hwdata[tws_pkg::STAT_BE]) begin
                berr_q <= 1'b0;
            end
            if (ev_addr) begin
                dir_q <= in_byte[0];
            end
            if ((state_q == tws_pkg::ST_TACK) & scl_rise) begin
                rnack_q <= sda_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake-up stretch: ends only when the sleep indication drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_q <= 1'b0;
        end else if (ev_start & sleeping) begin
            wake_q <= 1'b1;
        end else if (!sleeping) begin
            wake_q <= 1'b0;
        end
    end

    // scl hold: start pulling only once the line is already low
    assign hold_req = dflag_q | aflag_q | wake_q | tx_pend_q |
                      (state_q == tws_pkg::ST_HOLD);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= hold_req & (drv_q | ~scl_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command latch; applied only while scl is low so sda cannot glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q    <= 1'b0;
            cmd_q     <= 2'h0;
            tx_pend_q <= 1'b0;
        end else begin
            if (cmd_go) begin
                pend_q <= 1'b1;
                cmd_q  <= hwdata[tws_pkg::CMD_HI:tws_pkg::CMD_LO];
            end else if (ev_start | ((state_q != tws_pkg::ST_HOLD) &
                                      (state_q != tws_pkg::ST_TXW)) | ~scl_s) begin
                pend_q <= 1'b0;
            end
            if (wr_data & (state_q == tws_pkg::ST_TXW)) begin
                tx_pend_q <= 1'b1;
            end else if (state_q != tws_pkg::ST_TXW) begin
                tx_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte engine; no bus timeout, a stalled master leaves it waiting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= tws_pkg::ST_IDLE;
            sh_q      <= 8'h00;
            cnt_q     <= 3'h0;
            sda_drv_q <= 1'b0;
            is_addr_q <= 1'b0;
            rxd_q     <= 8'h00;
        end else if (!en) begin
            state_q   <= tws_pkg::ST_IDLE;
            sda_drv_q <= 1'b0;
        end else if (ev_start) begin
            state_q   <= tws_pkg::ST_ADDR; // repeated start accepted anywhere
            cnt_q     <= 3'h0;
            sda_drv_q <= 1'b0;
        end else if (ev_stop | ev_coll) begin
            state_q   <= tws_pkg::ST_IDLE;
            sda_drv_q <= 1'b0;
        end else begin
            case (state_q)
                tws_pkg::ST_IDLE: begin
                    sda_drv_q <= 1'b0;
                end
                tws_pkg::ST_ADDR, tws_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_q  <= in_byte;
                        cnt_q <= cnt_q + 3'h1;
                    end
                    if (last_rise) begin
                        is_addr_q <= (state_q == tws_pkg::ST_ADDR);
                        rxd_q     <= in_byte;
                        if ((state_q == tws_pkg::ST_RX) | ev_addr) begin
                            state_q <= tws_pkg::ST_HOLD;
                        end else begin
                            state_q <= tws_pkg::ST_IDLE;
                        end
                    end
                end
                tws_pkg::ST_HOLD: begin
                    if (pend_q & ~scl_s) begin
                        if (is_addr_q & dir_q & (cmd_q == tws_pkg::CMD_DONE)) begin
                            state_q <= tws_pkg::ST_IDLE;
                        end else if (cmd_q[1]) begin
                            state_q   <= tws_pkg::ST_ACK;
                            sda_drv_q <= ~ack_act_q;
                        end
                    end
                end
                tws_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        sda_drv_q <= 1'b0;
                        cnt_q     <= 3'h0;
                        if (ack_act_q | (cmd_q == tws_pkg::CMD_DONE)) begin
                            state_q <= tws_pkg::ST_IDLE;
                        end else if (is_addr_q & dir_q) begin
                            state_q <= tws_pkg::ST_TXW;
                        end else begin
                            state_q <= tws_pkg::ST_RX;
                        end
                    end
                end
                tws_pkg::ST_TXW: begin
                    if (pend_q & ~scl_s & (cmd_q == tws_pkg::CMD_DONE)) begin
                        state_q <= tws_pkg::ST_IDLE;
                    end else if (tx_pend_q & ~scl_s) begin
                        state_q   <= tws_pkg::ST_TX;
                        sh_q      <= txd_q;
                        sda_drv_q <= ~txd_q[7];
                        cnt_q     <= 3'h0;
                    end
                end
                tws_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == 3'h7) begin
                            state_q   <= tws_pkg::ST_TACK;
                            sda_drv_q <= 1'b0;
                        end else begin
                            sh_q      <= {sh_q[6:0], 1'b0};
                            sda_drv_q <= ~sh_q[6];
                            cnt_q     <= cnt_q + 3'h1;
                        end
                    end
                end
                tws_pkg::ST_TACK: begin
                    if (scl_rise) begin
                        state_q <= sda_s ? tws_pkg::ST_IDLE : tws_pkg::ST_TXW;
                    end
                end
                default: begin
                    state_q <= tws_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain pins: only ever pull low, enable low while pulling
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_n = ~drv_q;
    assign sda_oe_n = ~sda_drv_q;

endmodule // tws_slave

`default_nettype wire

// [sim/tws_properties.sv]
// concurrent checks on the ports of the two-wire slave engine
`timescale 1ns/1ps
`default_nettype none
module tws_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe_n,
    input wire logic        sda_o,
    input wire logic        sda_oe_n,
    input wire logic        sleeping
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // the clock is only ever grabbed or let go while the wire is already low
    chk_pull_after_low: assert property ($fell(scl_oe_n) |-> !$past(scl_i))
        else $error("scl pulled while the line was high");
    chk_free_when_low: assert property ($rose(scl_oe_n) |-> !$past(scl_i))
        else $error("scl released while the line was high");
    // a stretch lasts at least three cycles, never a single glitch
    chk_hold_stands: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*3])
        else $error("scl hold dropped too early");
    chk_sleep_hold: assert property ($rose(scl_oe_n) |-> !$past(sleeping))
        else $error("scl released while asleep");
    chk_sda_when_low: assert property ($changed(sda_oe_n) |-> !$past(scl_i))
        else $error("sda moved while scl high");
    chk_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("line driven high");
    chk_rdata_idle: assert property (!$past(hsel && hready && htrans[1]) |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    chk_bus_answer: assert property (hreadyout && !hresp)
        else $error("bus wait or error response");
    cover property ($fell(scl_oe_n));
    cover property (sleeping && !scl_oe_n);
    cover property ($fell(sda_oe_n));
endmodule // tws_properties
bind tws_slave tws_properties tws_properties_i (.hclk, .hresetn, .hsel, .htrans, .hready,
    .hrdata, .hreadyout, .hresp, .scl_i, .scl_o, .scl_oe_n, .sda_o, .sda_oe_n, .sleeping);
`default_nettype wire

// [sim/tws_bus_master.sv]
// behavioural two-wire bus master; the clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module tws_bus_master (
    input  wire logic scl,
    input  wire logic sda,
    output var logic  scl_m,
    output var logic  sda_m
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // one clock bit; sda is never moved in the same instant as scl
    task pulse(output logic v);
        #20 scl_m = 1'b1;
        wait (scl === 1'b1);
        #20 v = sda;
        #20 scl_m = 1'b0;
        #20;
    endtask
    task start;
        wait (scl === 1'b1 && sda === 1'b1);
        #20 sda_m = 1'b0;
        #40 scl_m = 1'b0;
        #20;
    endtask
    task stop;
        sda_m = 1'b0;
        #20 scl_m = 1'b1;
        wait (scl === 1'b1);
        #40 sda_m = 1'b1;
        #40;
    endtask
    // msb first, then the slave's answer bit
    task send(input logic [7:0] d, output logic ack_n);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            sda_m = d[i];
            pulse(v);
            if (d[i] && !v) begin
                ack_n = 1'b1;
                return;
            end
        end
        sda_m = 1'b1;
        pulse(ack_n);
    endtask
    task recv(output logic [7:0] d, input logic nack);
        logic v;
        sda_m = 1'b1;
        for (int i = 7; i >= 0; i--) pulse(d[i]);
        sda_m = nack;
        pulse(v);
        sda_m = 1'b1;
    endtask
endmodule // tws_bus_master
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench: register traffic and link frames against the slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleeping = 0, ack;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic        hreadyout, hresp, scl_o, sda_o, scl_oe_n, sda_oe_n, scl_m, sda_m;
    logic [7:0]  r, b;
    int          err_total = 0, num_checks = 0, cyc = 0;
    wire         scl = scl_m & scl_oe_n;
    wire         sda = sda_m & sda_oe_n;
    always #5 hclk = ~hclk;
    tws_slave tws_slave_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .scl_i(scl), .scl_o,
        .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n, .sleeping);
    tws_bus_master mst (.scl, .sda, .scl_m, .sda_m);
    ////////////////////////////////////////////////////////////
    task print_verdict;
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard, well above the several hundred cycles the frames need
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict;
        end
    end
    // one single transfer; read byte left in r
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata[7:0];
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task poll(input int k);
        do xfer(1'b0, tws_pkg::OFF_STAT, 8'h00); while (r[k] !== 1'b1);
    endtask
    task stat(input string n, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, tws_pkg::OFF_STAT, 8'h00);
        chk(n, e, r & m);
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, tws_pkg::OFF_CTRL, 8'h00);
        chk("ctrl reset", tws_pkg::CTRL_RST, r);
        xfer(1'b0, 8'h14, 8'h00);
        chk("unmapped", 8'h00, r);
        xfer(1'b1, tws_pkg::OFF_ADDR, 8'ha0);
        xfer(1'b1, tws_pkg::OFF_CTRL, 8'h0c);
        // master write to own address, one data byte, then stop
        mst.start;
        fork
            mst.send(8'ha0, ack);
            begin
                poll(tws_pkg::STAT_CH);
                chk("addr stat", 8'h61, r);
                xfer(1'b1, tws_pkg::OFF_CMD, 8'h03);
            end
        join
        chk("addr ack", 8'h00, {7'h0, ack});
        fork
            mst.send(8'h5a, ack);
            begin
                poll(tws_pkg::STAT_CH);
                chk("rx stat", 8'ha0, r & 8'he0);
                xfer(1'b0, tws_pkg::OFF_DATA, 8'h00);
                chk("rx data", 8'h5a, r);
                xfer(1'b1, tws_pkg::OFF_CMD, 8'h03);
            end
        join
        chk("rx ack", 8'h00, {7'h0, ack});
        stat("flags after cmd", 8'he0, 8'h00);
        mst.stop;
        stat("stop flag", 8'h41, 8'h40);
        xfer(1'b1, tws_pkg::OFF_STAT, 8'hcc);
        // start while asleep, then a foreign address with stop events off
        xfer(1'b1, tws_pkg::OFF_CTRL, 8'h08);
        sleeping <= 1'b1;
        mst.start;
        repeat (10) @(posedge hclk);
        chk("wake hold", 8'h00, {7'h0, scl_oe_n});
        sleeping <= 1'b0;
        mst.send(8'h66, ack);
        chk("foreign nack", 8'h01, {7'h0, ack});
        mst.stop;
        stat("no stop flag", 8'h40, 8'h00);
        // general call, refused
        xfer(1'b1, tws_pkg::OFF_ADDR, 8'ha1);
        mst.start;
        fork
            mst.send(8'h00, ack);
            begin
                poll(tws_pkg::STAT_CH);
                chk("gc stat", 8'h61, r);
                xfer(1'b1, tws_pkg::OFF_CMD, 8'h06);
            end
        join
        chk("gc nack", 8'h01, {7'h0, ack});
        mst.stop;
        // accept-all read: one byte out, master refuses it
        xfer(1'b1, tws_pkg::OFF_CTRL, 8'h0a);
        mst.start;
        fork
            mst.send(8'h67, ack);
            begin
                poll(tws_pkg::STAT_CH);
                chk("read stat", 8'h63, r);
                xfer(1'b1, tws_pkg::OFF_CMD, 8'h03);
            end
        join
        chk("read ack", 8'h00, {7'h0, ack});
        fork
            mst.recv(b, 1'b1);
            begin
                poll(tws_pkg::STAT_DF);
                xfer(1'b1, tws_pkg::OFF_DATA, 8'hc3);
            end
        join
        chk("tx byte", 8'hc3, b);
        stat("master nack", 8'h10, 8'h10);
        mst.stop;
        // stop straight after start, then clear the error
        mst.start;
        mst.stop;
        stat("bus error", 8'h04, 8'h04);
        xfer(1'b1, tws_pkg::OFF_STAT, 8'hcc);
        stat("error cleared", 8'h04, 8'h00);
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
